// >>> logic/sscp_port.sv
/*
 * Serial programming port, buffer-to-bank update logic and control word.
 * Serial side runs on the host serial clock; bank and update run on clk_sys_in.
 * Assumes two-way pins are resolved outside from the enables.
 */
//
// Contract
// [R1] Chip select high floats data, suspends cycle
// [R2] Control bit 0 picks read pin
// [R3] Resync input aborts cycle, keeps registers
// [R4] Config bits act on update immediately
// [R5] After register bytes, next byte is instruction
// [R6] Control bit 1 selects LSB first
// [R7] Serial writes buffered, bank copied on sysclk
// [R8] External update edge copies once
// [R9] Internal update pulses strobe eight cycles
// [R10] Rate register is half update period
// [R11] Rate below five keeps strobe high
// [R12] 32-bit control word at 1D..20
// [R13] Power-down bits active high, default zero
// [R14] Host writes zero to bits 27,23,7,3:2
// [R15] PLL gain and bypass reset set
// [R16] PLL multiplier from bits 20:16
// [R17] Bit 15 pulses accumulator clear once
// [R18] Bit 14 holds accumulators at zero
// [R19] Bit 13 selects triangle sweep
// [R20] Bits 11:9 select operating mode
// [R21] Bit 6 bypasses inverse sinc filter
// [R22] Bits 5,4 control shaped keying
// [R23] Instruction: bit7 read, bits3:0 address
// [R24] Data phase carries all register bytes
// [R25] Sample rising edge, drive falling edge
// [R26] Bank changes only on update events
`timescale 1ns/10ps
`default_nettype none
module sscp_port
	import sscp_pkg::*;
(
	input  wire logic                        clk_sys_in,
	input  wire logic                        rst_b_in,
	input  wire logic                        sclk_in,
	input  wire logic                        cs_b_in,
	input  wire logic                        io_reset_in,
	input  wire logic                        sdio_in,
	output logic                             sdio_out,
	output logic                             sdio_oe_out,
	output logic                             sdo_out,
	output logic                             sdo_oe_out,
	input  wire logic                        update_strobe_in,
	output logic                             update_strobe_out,
	output logic                             update_strobe_oe_out,
	output logic                             bank_we_out,
	output logic      [sscp_pkg::REG_AW-1:0] bank_index_out,
	output logic      [sscp_pkg::REG_DW-1:0] bank_data_out,
	output logic      [sscp_pkg::CTRL_W-1:0] control_word_out,
	output logic                             clear_acc1_out,
	output logic                             hold_acc_out,
	output logic                             triangle_out,
	output logic      [2:0]                  op_mode_out,
	output logic                             pd_comparator_out,
	output logic                             pd_control_dac_out,
	output logic                             pd_dacs_out,
	output logic                             pd_digital_out,
	output logic                             pll_high_gain_out,
	output logic                             pll_bypass_out,
	output logic      [4:0]                  pll_mult_out,
	output logic                             bypass_isinc_out,
	output logic                             shaped_key_en_out,
	output logic                             shaped_key_int_out
);
	import sscp_pkg::*;

	typedef struct packed {
		logic                 instr_done;
		logic                 rd;
		logic [REG_AW-1:0]    idx;
		logic [7:0]           instr;
		logic [2:0]           bitc;
		logic [BIT_CNT_W-1:0] dcnt;
		logic [REG_DW-1:0]    word;
	} sscp_ser_t;

	typedef struct packed {
		logic              upd_prev;
		logic              walking;
		logic              pending;
		logic [REG_AW-1:0] widx;
		logic              rd_valid;
		logic [REG_AW-1:0] ridx;
		logic [CTRL_W-1:0] ctrl;
		logic [CTRL_W-1:0] rate;
		logic [CTRL_W:0]   cnt;
		logic [3:0]        pulse;
		logic              bank_we;
		logic [REG_AW-1:0] bank_idx;
		logic [REG_DW-1:0] bank_data;
		logic              clr_acc1;
	} sscp_sys_t;

	sscp_ser_t         ser_q, ser_d;
	sscp_sys_t         sys_q, sys_d;
	logic              ser_rst_b;
	logic [1:0]        cfg_sclk;
	logic              lsb_first;
	logic              sdo_active;
	logic              mem_we;
	logic [REG_AW-1:0] mem_addr_a;
	logic [REG_DW-1:0] mem_rdata_a;
	logic [REG_DW-1:0] mem_rdata_b;
	logic [REG_DW-1:0] wr_word;
	logic [7:0]        instr_next;
	logic [BIT_CNT_W-1:0] nbits;
	logic              out_bit_q;
	logic              rd_phase;
	logic              upd_sync;
	logic              upd_event;
	logic              rate_low;

	////////////////////////////////////////////////////////////////////////////
	// Serial clock domain

	// [R3] Resync clears port
	assign ser_rst_b = rst_b_in & ~io_reset_in;

	// [R4] Config crosses live
	sscp_sync2 #(.W(2)) u_cfg_sync (
		.clk_in   (sclk_in),
		.rst_b_in (ser_rst_b),
		.d_in     ({sys_q.ctrl[CB_LSB_FIRST], sys_q.ctrl[CB_SDO_ACTIVE]}),
		.q_out    (cfg_sclk)
	);
	assign lsb_first  = cfg_sclk[1];
	assign sdo_active = cfg_sclk[0];

	// [R6] Reorder at byte end, config settled by then
	assign instr_next = lsb_first ?
		{sdio_in, ser_q.instr[0], ser_q.instr[1], ser_q.instr[2], ser_q.instr[3],
		ser_q.instr[4], ser_q.instr[5], ser_q.instr[6]} : {ser_q.instr[6:0], sdio_in};
	assign nbits      = sscp_reg_bits(ser_q.idx);
	assign mem_addr_a = ser_q.instr_done ? ser_q.idx : instr_next[INSTR_ADDR_HI:0];

	always_comb begin
		wr_word = ser_q.word;
		if (lsb_first) begin
			wr_word[ser_q.dcnt] = sdio_in;
		end else begin
			wr_word = {ser_q.word[REG_DW-2:0], sdio_in};
		end
	end

	always_comb begin
		ser_d  = ser_q;
		mem_we = 1'b0;
		// [R1] Suspend while deselected
		if (!cs_b_in) begin
			if (!ser_q.instr_done) begin
				ser_d.instr = {ser_q.instr[6:0], sdio_in};
				ser_d.bitc  = ser_q.bitc + 3'h1;
				// [R23] Decode instruction byte
				if (ser_q.bitc == INSTR_LAST_BIT) begin
					ser_d.instr_done = 1'b1;
					ser_d.rd         = instr_next[INSTR_RW_BIT];
					ser_d.idx        = instr_next[INSTR_ADDR_HI:0];
					ser_d.dcnt       = '0;
					ser_d.word       = '0;
				end
			end else begin
				ser_d.word = wr_word;
				ser_d.dcnt = ser_q.dcnt + 6'h1;
				// [R24] Whole register per phase
				if (ser_q.dcnt == nbits - 6'h1) begin
					// [R5] Back to instruction phase
					ser_d.instr_done = 1'b0;
					ser_d.bitc       = '0;
					// [R7] Write only the buffer
					mem_we = ~ser_q.rd & (ser_q.idx <= IDX_LAST);
				end
			end
		end
	end

	// [R25] Sample rising edge
	always_ff @(posedge sclk_in or negedge ser_rst_b) begin
		if (!ser_rst_b) begin
			ser_q <= '0;
		end else begin
			ser_q <= ser_d;
		end
	end

	// [R25] Drive on falling edge
	always_ff @(negedge sclk_in or negedge ser_rst_b) begin
		if (!ser_rst_b) begin
			out_bit_q <= 1'b0;
		end else if (lsb_first) begin
			out_bit_q <= mem_rdata_a[ser_q.dcnt];
		end else begin
			out_bit_q <= mem_rdata_a[nbits - 6'h1 - ser_q.dcnt];
		end
	end

	// [R2] Read pin selection
	assign rd_phase    = ser_q.instr_done & ser_q.rd & ~cs_b_in;
	assign sdio_out    = out_bit_q;
	assign sdo_out     = out_bit_q;
	assign sdio_oe_out = rd_phase & ~sdo_active;
	assign sdo_oe_out  = rd_phase & sdo_active;

	sscp_buf_mem u_buf (
		.wclk_in     (sclk_in),
		.rst_b_in    (rst_b_in),
		.we_in       (mem_we),
		.addr_a_in   (mem_addr_a),
		.wdata_in    (wr_word),
		.rdata_a_out (mem_rdata_a),
		.rclk_in     (clk_sys_in),
		.addr_b_in   (sys_q.widx),
		.rdata_b_out (mem_rdata_b)
	);

	////////////////////////////////////////////////////////////////////////////
	// System clock domain

	sscp_sync2 #(.W(1)) u_upd_sync (
		.clk_in   (clk_sys_in),
		.rst_b_in (rst_b_in),
		.d_in     (update_strobe_in),
		.q_out    (upd_sync)
	);

	assign rate_low = sys_q.rate < UPD_RATE_MIN;
	always_comb begin
		sys_d          = sys_q;
		sys_d.upd_prev = upd_sync;
		sys_d.bank_we  = 1'b0;
		sys_d.clr_acc1 = 1'b0;
		sys_d.rd_valid = sys_q.walking;
		sys_d.ridx     = sys_q.widx;
		upd_event      = 1'b0;
		if (sys_q.pulse != 4'h0) begin
			sys_d.pulse = sys_q.pulse - 4'h1;
		end
		if (sys_q.ctrl[CB_INT_UPDATE]) begin
			// [R10] Period of twice rate
			if (sys_q.cnt == '0) begin
				upd_event   = 1'b1;
				sys_d.cnt   = (sys_q.rate == '0) ? '0 : {sys_q.rate, 1'b0} - 33'h1;
				// [R9] Eight-cycle strobe pulse
				sys_d.pulse = UPD_PULSE_CYCLES;
			end else begin
				sys_d.cnt = sys_q.cnt - 33'h1;
			end
		end else begin
			sys_d.cnt = '0;
			// [R8] Rising edge only
			upd_event = upd_sync & ~sys_q.upd_prev;
		end
		// [R26] Start walk on event
		if (sys_q.walking) begin
			sys_d.pending = sys_q.pending | upd_event;
			sys_d.widx    = sys_q.widx + 4'h1;
			if (sys_q.widx == IDX_LAST) begin
				sys_d.walking = 1'b0;
			end
		end else if (upd_event || sys_q.pending) begin
			sys_d.walking = 1'b1;
			sys_d.pending = 1'b0;
			sys_d.widx    = '0;
		end
		// [R7] Copy buffer into bank
		if (sys_q.rd_valid) begin
			sys_d.bank_we   = 1'b1;
			sys_d.bank_idx  = sys_q.ridx;
			sys_d.bank_data = mem_rdata_b;
			if (sys_q.ridx == IDX_UPDATE_RATE) begin
				sys_d.rate = mem_rdata_b[CTRL_W-1:0];
			end
			// [R12] Control word load
			if (sys_q.ridx == IDX_CONTROL) begin
				sys_d.ctrl = mem_rdata_b[CTRL_W-1:0];
				// [R17] One-shot, active bit self-clears
				sys_d.ctrl[CB_CLR_ACC1] = 1'b0;
				sys_d.clr_acc1          = mem_rdata_b[CB_CLR_ACC1];
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_b_in) begin
			sys_q      <= '0;
			// [R15] PLL bits reset set
			sys_q.ctrl <= CTRL_RESET;
		end else begin
			sys_q <= sys_d;
		end
	end
	// [R11] Low rate holds strobe high
	assign update_strobe_out    = sys_q.ctrl[CB_INT_UPDATE] & ((sys_q.pulse != 4'h0) | rate_low);
	assign update_strobe_oe_out = sys_q.ctrl[CB_INT_UPDATE];

	assign bank_we_out        = sys_q.bank_we;
	assign bank_index_out     = sys_q.bank_idx;
	assign bank_data_out      = sys_q.bank_data;
	assign control_word_out   = sys_q.ctrl;
	assign clear_acc1_out     = sys_q.clr_acc1;
	// [R18] Hold accumulators
	assign hold_acc_out       = sys_q.ctrl[CB_CLR_ACC];
	// [R19] Triangle sweep
	assign triangle_out       = sys_q.ctrl[CB_TRIANGLE];
	// [R20] Operating mode
	assign op_mode_out        = sys_q.ctrl[CB_MODE_HI:CB_MODE_LO];
	// [R13] Power-down controls
	assign pd_comparator_out  = sys_q.ctrl[CB_PD_COMPARATOR];
	assign pd_control_dac_out = sys_q.ctrl[CB_PD_CTRL_DAC];
	assign pd_dacs_out        = sys_q.ctrl[CB_PD_DACS];
	assign pd_digital_out     = sys_q.ctrl[CB_PD_DIGITAL];
	// [R15] PLL gain and bypass
	assign pll_high_gain_out  = sys_q.ctrl[CB_PLL_HIGH_GAIN];
	assign pll_bypass_out     = sys_q.ctrl[CB_PLL_BYPASS];
	// [R16] PLL multiplier
	assign pll_mult_out       = sys_q.ctrl[CB_PLL_MULT_HI:CB_PLL_MULT_LO];
	// [R21] Inverse sinc bypass
	assign bypass_isinc_out   = sys_q.ctrl[CB_ISINC_BYPASS];
	// [R22] Shaped keying controls
	assign shaped_key_en_out  = sys_q.ctrl[CB_SHAPE_EN];
	assign shaped_key_int_out = sys_q.ctrl[CB_SHAPE_INT];

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence ext_edge_s;
		!sys_q.ctrl[CB_INT_UPDATE] && upd_sync && !sys_q.upd_prev;
	endsequence
	sequence full_walk_s;
		sys_q.walking[*8] ##1 sys_q.walking[*4] ##1 !sys_q.walking;
	endsequence
	upd_pulse_len_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R9]
		$rose(sys_q.pulse != 4'h0) && sys_q.ctrl[CB_INT_UPDATE] |-> update_strobe_out[*8])
		else $error("update strobe pulse shorter than eight cycles");
	low_rate_high_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R11]
		sys_q.ctrl[CB_INT_UPDATE] && rate_low |-> update_strobe_out)
		else $error("update strobe dropped with low rate");
	ext_edge_xfer_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R8]
		ext_edge_s and !sys_q.walking |=> sys_q.walking && sys_q.widx == 4'h0)
		else $error("external edge did not start transfer");
	no_repeat_xfer_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R8]
		!sys_q.ctrl[CB_INT_UPDATE] && upd_sync && sys_q.upd_prev && !sys_q.walking
		&& !sys_q.pending |=> !sys_q.walking)
		else $error("held update level repeated transfer");
	walk_length_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R7]
		$rose(sys_q.walking) |-> full_walk_s)
		else $error("bank transfer length wrong");
	rate_reload_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R10]
		sys_q.ctrl[CB_INT_UPDATE] && sys_q.cnt == '0 && sys_q.rate != '0
		|=> sys_q.cnt == {$past(sys_q.rate), 1'b0} - 33'h1)
		else $error("update period not twice rate");
	acc1_once_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R17]
		sys_q.clr_acc1 |=> !sys_q.clr_acc1 && !sys_q.ctrl[CB_CLR_ACC1])
		else $error("accumulator clear not one-shot");
	ctrl_on_xfer_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R26]
		$changed(sys_q.ctrl) |-> $past(sys_q.rd_valid) && $past(sys_q.ridx) == IDX_CONTROL)
		else $error("control word changed outside transfer");
	float_deselect_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // [R1]
		cs_b_in |-> !sdio_oe_out && !sdo_oe_out)
		else $error("data pin driven while deselected");
	instr_after_data_a: assert property (@(posedge sclk_in) disable iff (!ser_rst_b) // [R5]
		!cs_b_in && ser_q.instr_done && ser_q.dcnt == nbits - 6'h1 |=> !ser_q.instr_done)
		else $error("instruction phase not resumed");
endmodule // sscp_port
`default_nettype wire

// >>> logic/sscp_pkg.sv
/*
 * Constants, field positions and helpers for the synthesizer serial control port.
 * Assumes a 40 MHz system clock and a host-driven serial clock of up to 10 MHz.
 */
`default_nettype none
package sscp_pkg;
	localparam int          NUM_REGS          = 12;
	localparam int          REG_AW            = 4;
	localparam int          REG_DW            = 48;
	localparam int          CTRL_W            = 32;
	localparam int          BIT_CNT_W         = 6;
	localparam logic [3:0]  IDX_UPDATE_RATE   = 4'h5;
	localparam logic [3:0]  IDX_CONTROL       = 4'h7;
	localparam logic [3:0]  IDX_LAST          = 4'hb;
	localparam logic [7:0]  CTRL_BYTE_FIRST   = 8'h1d;
	localparam logic [7:0]  CTRL_BYTE_LAST    = 8'h20;
	localparam logic [31:0] CTRL_RESET        = 32'h0060_0000;
	localparam logic [2:0]  INSTR_LAST_BIT    = 3'h7;
	localparam int          INSTR_RW_BIT      = 7;
	localparam int          INSTR_ADDR_HI     = 3;
	// Control word field positions
	localparam int          CB_SDO_ACTIVE     = 0;
	localparam int          CB_LSB_FIRST      = 1;
	localparam int          CB_SHAPE_INT      = 4;
	localparam int          CB_SHAPE_EN       = 5;
	localparam int          CB_ISINC_BYPASS   = 6;
	localparam int          CB_INT_UPDATE     = 8;
	localparam int          CB_MODE_LO        = 9;
	localparam int          CB_MODE_HI        = 11;
	localparam int          CB_TRIANGLE       = 13;
	localparam int          CB_CLR_ACC        = 14;
	localparam int          CB_CLR_ACC1       = 15;
	localparam int          CB_PLL_MULT_LO    = 16;
	localparam int          CB_PLL_MULT_HI    = 20;
	localparam int          CB_PLL_BYPASS     = 21;
	localparam int          CB_PLL_HIGH_GAIN  = 22;
	localparam int          CB_PD_DIGITAL     = 24;
	localparam int          CB_PD_DACS        = 25;
	localparam int          CB_PD_CTRL_DAC    = 26;
	localparam int          CB_PD_COMPARATOR  = 28;
	// Update strobe timing, in system clock cycles
	localparam logic [3:0]  UPD_PULSE_CYCLES  = 4'h8;
	localparam logic [31:0] UPD_RATE_MIN      = 32'h0000_0005;
	localparam int          UPD_EXT_MIN_HIGH  = 2;

	// Byte count of each register in a data phase; unmapped slots take two
	function automatic logic [2:0] sscp_reg_bytes(input logic [3:0] idx);
		unique case (idx)
			4'h2, 4'h3, 4'h4: sscp_reg_bytes = 3'h6;
			4'h5, 4'h7:       sscp_reg_bytes = 3'h4;
			4'h6:             sscp_reg_bytes = 3'h3;
			default:          sscp_reg_bytes = 3'h2;
		endcase
	endfunction

	function automatic logic [BIT_CNT_W-1:0] sscp_reg_bits(input logic [3:0] idx);
		sscp_reg_bits = {sscp_reg_bytes(idx), 3'h0};
	endfunction

	function automatic logic [REG_DW-1:0] sscp_reset_value(input logic [3:0] idx);
		sscp_reset_value = (idx == IDX_CONTROL) ? {16'h0000, CTRL_RESET} : 48'h0000_0000_0000;
	endfunction
endpackage
`default_nettype wire

// >>> logic/sscp_sync2.sv
/*
 * Two flip-flop level synchroniser.
 * Assumes the destination clock and an active-low reset of that domain.
 */
`timescale 1ns/10ps
`default_nettype none
module sscp_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_q <= '0;
			q_out  <= '0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule // sscp_sync2
`default_nettype wire

// >>> logic/sscp_buf_mem.sv
/*
 * Buffer memory of the programming port: written and read on the serial clock,
 * read again on the system clock for transfers into the active bank.
 * Assumes the host does not write while a transfer walks the buffer.
 */
`timescale 1ns/10ps
`default_nettype none
module sscp_buf_mem
	import sscp_pkg::*;
(
	input  wire logic                       wclk_in,
	input  wire logic                       rst_b_in,
	input  wire logic                       we_in,
	input  wire logic [sscp_pkg::REG_AW-1:0] addr_a_in,
	input  wire logic [sscp_pkg::REG_DW-1:0] wdata_in,
	output logic      [sscp_pkg::REG_DW-1:0] rdata_a_out,
	input  wire logic                       rclk_in,
	input  wire logic [sscp_pkg::REG_AW-1:0] addr_b_in,
	output logic      [sscp_pkg::REG_DW-1:0] rdata_b_out
);
	logic [REG_DW-1:0] mem_q [NUM_REGS];

	for (genvar i = 0; i < NUM_REGS; i++) begin : g_word
		always_ff @(posedge wclk_in or negedge rst_b_in) begin
			if (!rst_b_in) begin
				mem_q[i] <= sscp_reset_value(4'(i));
			end else if (we_in && addr_a_in == 4'(i)) begin
				mem_q[i] <= wdata_in;
			end
		end
	end

	always_ff @(posedge wclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rdata_a_out <= '0;
		end else begin
			rdata_a_out <= (addr_a_in <= IDX_LAST) ? mem_q[addr_a_in] : '0;
		end
	end

	always_ff @(posedge rclk_in) begin
		rdata_b_out <= (addr_b_in <= IDX_LAST) ? mem_q[addr_b_in] : '0;
	end
endmodule // sscp_buf_mem
`default_nettype wire

// >>> test/sscp_host_model.sv
/*
 * Behavioural serial host for the control port.
 * Assumes the bench resolves the data pins from the enables.
 */
`timescale 1ns/10ps
`default_nettype none
module sscp_host_model (
	output logic     sclk_out,
	output logic     cs_b_out,
	output logic     sdio_out,
	input  wire logic sdio_line_in,
	input  wire logic sdo_line_in
);
	initial begin
		sclk_out = 1'b0;
		cs_b_out = 1'b1;
		sdio_out = 1'b0;
	end
	// Clock stands still between frames
	task automatic xfer(input logic [7:0] ins, input int nb, input logic lsb, input logic so,
		input logic keep, input int stop, input int susp, input logic [47:0] wd,
		output logic [47:0] rd);
		int n;
		int k;
		n = 8 + nb * 8;
		rd = '0;
		cs_b_out = 1'b0;
		#47.3;
		for (int i = 0; i < n; i++) begin
			if (i == stop) break;
			if (i == susp) begin
				cs_b_out = 1'b1;
				repeat (2) begin
					sdio_out = ~sdio_out;
					#62.5 sclk_out = 1'b1;
					#62.5 sclk_out = 1'b0;
				end
				cs_b_out = 1'b0;
				#20;
			end
			k = lsb ? (i < 8 ? i : i - 8) : (i < 8 ? 7 - i : n - 1 - i);
			if (i < 8) sdio_out = ins[k];
			else if (ins[7]) sdio_out = ~sdio_out;
			else sdio_out = wd[k];
			#62.5 sclk_out = 1'b1;
			if (i >= 8) rd[k] = so ? sdo_line_in : sdio_line_in;
			#62.5 sclk_out = 1'b0;
		end
		// frames may follow in one select
		if (!keep) begin
			#40 cs_b_out = 1'b1;
		end
		#100;
	endtask
endmodule // sscp_host_model
`default_nettype wire

// >>> test/synth_serial_control_port_bench.sv
/*
 * Self-checking bench of the control port: serial host model, update pin, checks.
 * Assumes the port module and package from logic/.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("BAD %s exp %0h got %0h", nm, ex, got); end end
module synth_serial_control_port_bench;
	import sscp_pkg::*;
	logic clk, rst_b, ud_drv, io_rst, lsb_m, sdo_m, sclk_w, cs_b_w, sdio_h;
	logic sdio_o, sdio_oe, sdo_o, sdo_oe, ud_o, ud_oe, we, clr1, hold, tri_o;
	logic pdc, pdk, pdd, pdg, hg, byp, isb, ske, ski;
	logic [3:0] bidx;
	logic [47:0] bdat, rv;
	logic [31:0] cw, c, prev, e;
	logic [2:0] mode;
	logic [4:0] mult;
	logic [31:0] exp_q[$];
	int checks, n_mismatch, n_we, n_clr, t, seed;
	wire sdio_w = sdio_oe ? sdio_o : sdio_h;
	wire sdo_w = sdo_oe ? sdo_o : ~sdio_h;
	wire ud_w = ud_oe ? ud_o : ud_drv;
	sscp_port dut_u (.clk_sys_in(clk), .rst_b_in(rst_b), .sclk_in(sclk_w), .cs_b_in(cs_b_w),
		.io_reset_in(io_rst), .sdio_in(sdio_w), .sdio_out(sdio_o), .sdio_oe_out(sdio_oe),
		.sdo_out(sdo_o), .sdo_oe_out(sdo_oe), .update_strobe_in(ud_w),
		.update_strobe_out(ud_o), .update_strobe_oe_out(ud_oe), .bank_we_out(we),
		.bank_index_out(bidx), .bank_data_out(bdat), .control_word_out(cw),
		.clear_acc1_out(clr1), .hold_acc_out(hold), .triangle_out(tri_o), .op_mode_out(mode),
		.pd_comparator_out(pdc), .pd_control_dac_out(pdk), .pd_dacs_out(pdd),
		.pd_digital_out(pdg), .pll_high_gain_out(hg), .pll_bypass_out(byp),
		.pll_mult_out(mult), .bypass_isinc_out(isb), .shaped_key_en_out(ske),
		.shaped_key_int_out(ski));
	sscp_host_model host_u (.sclk_out(sclk_w), .cs_b_out(cs_b_w), .sdio_out(sdio_h),
		.sdio_line_in(sdio_w), .sdo_line_in(sdo_w));
	////////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic complete_run;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		complete_run();
	end
	task automatic op(input logic [7:0] ins, input int nb, input logic keep, input int stop,
		input int susp, input logic [47:0] wd);
		host_u.xfer(ins, nb, lsb_m, sdo_m, keep, stop, susp, wd, rv);
	endtask
	task automatic upd(input int len);
		@(posedge clk) ud_drv <= 1'b1;
		repeat (len) @(posedge clk);
		ud_drv <= 1'b0;
		repeat (20) @(posedge clk);
	endtask
	task automatic wait_w0;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (!(we === 1'b1 && bidx === 4'h0) && t < 500);
	endtask
	function automatic logic [31:0] mk_ctrl(input logic [2:0] m);
		logic [31:0] r;
		logic [4:0] mu;
		r = $random(seed);
		mu = 5'(4 + ($unsigned($random(seed)) % 17));
		mk_ctrl = {3'h0, r[28], 1'b0, r[26:24], 1'b0, r[22:21], mu, 1'b0, r[14],
			(m == 3'h2) & r[13], 1'b0, m, 2'h0, r[6:4], 4'h0};
	endfunction
	////////////////////////////////////////////////////////////////////////////////////
	always @(negedge clk) if (rst_b && we === 1'b1) begin
		n_we++;
		if (bidx === IDX_CONTROL && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			`CHK("bank_ctrl", e, bdat[31:0])
		end
	end
	always @(negedge clk) if (clr1 === 1'b1) n_clr++;
	always @(negedge sclk_w) if (cs_b_w === 1'b1)
		`CHK("float_cs", 2'b00, {sdio_oe, sdo_oe})
	////////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 66571;
		{rst_b, ud_drv, io_rst, lsb_m, sdo_m} = '0;
		{checks, n_mismatch, n_we, n_clr} = '0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(negedge clk);
		`CHK("ctrl_reset", CTRL_RESET, cw)
		`CHK("ud_oe", 1'b0, ud_oe)
		prev = CTRL_RESET;
		for (int m = 0; m < 5; m++) begin
			c = mk_ctrl(3'(m));
			op({4'h0, IDX_CONTROL}, 4, 0, 99, 99, {16'h0, c});
			`CHK("ctrl_held", prev, cw)
			exp_q.push_back(c);
			n_we = 0;
			upd(m == 4 ? 40 : 3);
			`CHK("walk_count", NUM_REGS, n_we)
			`CHK("fields", {c[28], c[26:24], c[22:16], c[14:13], c[11:9], c[6:4]},
				{pdc, pdk, pdd, pdg, hg, byp, mult, hold, tri_o, mode, isb, ske, ski})
			prev = c;
		end
		op({4'h8, IDX_CONTROL}, 4, 0, 99, 20, '0);
		`CHK("ctrl_read", {16'h0, prev}, rv)
		c = $random(seed);
		op(8'h30, 2, 1, 99, 99, {32'h0, c[15:0]});
		op(8'hc0, 2, 0, 99, 99, '0);
		`CHK("back_to_back", {32'h0, c[15:0]}, rv)
		op(8'h0c, 2, 0, 99, 99, 48'hffff);
		op(8'h8c, 2, 0, 99, 99, '0);
		`CHK("unmapped", 48'h0, rv)
		op({4'h0, IDX_CONTROL}, 4, 0, 20, 99, 48'h0);
		@(posedge clk) io_rst <= 1'b1;
		repeat (4) @(posedge clk);
		io_rst <= 1'b0;
		op(8'h80, 2, 0, 99, 99, '0);
		`CHK("resync", {32'h0, c[15:0]}, rv)
		op({4'h8, IDX_CONTROL}, 4, 0, 99, 99, '0);
		`CHK("abort_keeps", {16'h0, prev}, rv)
		prev = prev | 32'h3;
		op({4'h0, IDX_CONTROL}, 4, 0, 99, 99, {16'h0, prev});
		exp_q.push_back(prev);
		upd(3);
		{lsb_m, sdo_m} = 2'b11;
		op({4'h8, IDX_CONTROL}, 4, 0, 99, 99, '0);
		`CHK("lsb_sdo_read", {16'h0, prev}, rv)
		n_clr = 0;
		op({4'h0, IDX_CONTROL}, 4, 0, 99, 99, {16'h0, prev | 32'h8000});
		upd(3);
		`CHK("clr_pulse", 1, n_clr)
		`CHK("clr_self", 1'b0, cw[15])
		op({4'h8, IDX_CONTROL}, 4, 0, 99, 99, '0);
		`CHK("clr_buf", 1'b1, rv[15])
		op({4'h0, IDX_UPDATE_RATE}, 4, 0, 99, 99, 48'ha);
		prev = prev | 32'h100;
		op({4'h0, IDX_CONTROL}, 4, 0, 99, 99, {16'h0, prev});
		exp_q.push_back(prev);
		upd(3);
		`CHK("ud_oe_int", 1'b1, ud_oe)
		wait_w0();
		wait_w0();
		`CHK("upd_period", 20, t)
		t = 0;
		while (ud_o !== 1'b0 && t < 100) begin @(negedge clk); t++; end
		while (ud_o !== 1'b1 && t < 100) begin @(negedge clk); t++; end
		t = 0;
		while (ud_o === 1'b1 && t < 100) begin @(negedge clk); t++; end
		`CHK("strobe_width", int'(UPD_PULSE_CYCLES), t)
		op({4'h0, IDX_UPDATE_RATE}, 4, 0, 99, 99, 48'h3);
		repeat (60) @(negedge clk);
		{t, n_we} = '0;
		repeat (40) begin @(negedge clk); if (ud_o !== 1'b1) t++; end
		`CHK("strobe_stuck", 0, t)
		`CHK("walks_go_on", 1'b1, n_we > 0)
		`CHK("queue_empty", 0, exp_q.size())
		complete_run();
	end
endmodule // synth_serial_control_port_bench
`default_nettype wire
